/* File: spc_pkg.sv */
// Purpose: Constants for the strap and pin configuration register group.
// Assumes: Indexed access through the extension data port.
// Notes:   Offsets are register indexes on the extension index port.
package spc_pkg;
   // ==========================================================
   // Register indexes
   localparam logic [7:0] SPC_IDX_SCRATCH = 8'h98;
   localparam logic [7:0] SPC_IDX_STRAP   = 8'h99;
   localparam logic [7:0] SPC_IDX_MEMW    = 8'h9A;
   localparam logic [7:0] SPC_IDX_MISC    = 8'h9B;
   // ==========================================================
   // Reset values and misc write mask
   localparam logic [7:0] SPC_SCRATCH_RST = 8'h00;
   localparam logic [7:0] SPC_MEMW_RST    = 8'h00;
   localparam logic [7:0] SPC_MISC_RST    = 8'h00;
   localparam logic [7:0] SPC_MISC_WMASK  = 8'h7B;
   localparam logic [4:0] SPC_STRAP_RST   = 5'h09;
   // ==========================================================
   // Field positions
   localparam int SPC_STRAP_ROM_EN   = 0;
   localparam int SPC_STRAP_ISA      = 1;
   localparam int SPC_STRAP_REDUCED  = 2;
   localparam int SPC_STRAP_SLEEP    = 3;
   localparam int SPC_STRAP_WIDTH    = 4;
   localparam int SPC_MISC_SQ_INV    = 0;
   localparam int SPC_MISC_SENSE_DIS = 1;
   localparam int SPC_MISC_P2_LO     = 3;
   localparam int SPC_MISC_P1_LO     = 5;
   // ==========================================================
   // Pin function encodings
   localparam logic [1:0] SPC_P1_LINE_CLK = 2'h0;
   localparam logic [1:0] SPC_P1_DATA_EN  = 2'h1;
   localparam logic [1:0] SPC_P2_INTERNAL = 2'h0;
   localparam logic [1:0] SPC_P2_MODULATE = 2'h1;
   // ==========================================================
   // Decoded sleep wake-up port addresses
   localparam logic [15:0] SPC_SLEEP_PORT_A = 16'h03C3;
   localparam logic [15:0] SPC_SLEEP_PORT_B = 16'h46E8;
endpackage : spc_pkg

/* File: spc_strap_pin_cfg.sv */
// Purpose: Scratch, strap, memory-width and miscellaneous pin configuration registers.
// Assumes: Index and data port decoding upstream gives index, write strobe and data.
// Notes:   Strap pins are asynchronous and pass a two-stage synchroniser.
//
// Contract
// - Eight-bit scratch register, read/write, with no effect on the device.
// - Strap register is read-only and shows pull-up presence; writes ignored.
// - Straps captured at reset and again when the latch bit falls from 1 to 0.
// - Captured straps drive hardware and read back in the strap register.
// - Strap bit 4 from frame address pin 8 selects ROM width.
// - Strap bit 3 from pin 7 selects sleep port 3C3h or 46E8h.
// - Strap bit 0 from pin 4 enables ROM decode at C000:0.
// - Memory-width register selects display width; only zero is defined.
// - Misc bits 6:5 choose line clock or data enable on panel pin.
// - Misc bits 6:5 ignored while companion colour mode is enabled.
// - Misc bits 4:3 choose internal or modulation on second pin.
// - Registers reached through data port 3CF at indexes 98 to 9B.
// - Misc bit 1 low enables monitor sense; high disables it.
// - Misc bit 0 high inverts memory sequencer clock phase.
// - Pins read while latch bit is 1, latched on its return to 0.
`timescale 1ns/1ns
module spc_strap_pin_cfg
   import spc_pkg::*;
(
   // Clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        nrst_in,
   // Indexed register port
   input  wire logic [7:0]  reg_index_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_wdata_in,
   output logic      [7:0]  reg_rdata_out,
   output logic             reg_hit_out,
   // Control from other extension registers
   input  wire logic        monitor_id_latch_bit_in,
   input  wire logic        companion_color_mode_enable_in,
   // Strap pins
   input  wire logic        frame_addr_pin_8_in,
   input  wire logic        frame_addr_pin_7_in,
   input  wire logic        frame_addr_pin_6_in,
   input  wire logic        frame_addr_pin_5_in,
   input  wire logic        frame_addr_pin_4_in,
   // Hardware controls
   output logic             rom_width_16_out,
   output logic [15:0]      sleep_port_addr_out,
   output logic             rom_decode_en_out,
   output logic             reduced_decode_out,
   output logic             isa_bus_sel_out,
   output logic [7:0]       memory_width_sel_out,
   output logic             panel_line_clock_sel_out,
   output logic             panel_data_enable_sel_out,
   output logic             panel_modulation_sel_out,
   output logic             monitor_sense_en_out,
   output logic             memory_sequencer_clock_inv_out
);

   // ==========================================================
   // Strap synchroniser and capture
   logic [4:0] strap_meta_reg;
   logic [4:0] strap_sync_reg;
   logic [4:0] strap_reg;
   logic [4:0] strap_next;
   logic       latch_d_reg;
   logic       capture_pend_reg;
   logic       latch_fall;

   // The pending flag makes the first sample after reset release come from settled pins.
   assign latch_fall = latch_d_reg & ~monitor_id_latch_bit_in;
   assign strap_next = (capture_pend_reg | latch_fall) ? strap_sync_reg : strap_reg;

   always_ff @(posedge clk_sys_in) begin
      strap_meta_reg <= {frame_addr_pin_8_in, frame_addr_pin_7_in, frame_addr_pin_6_in,
                         frame_addr_pin_5_in, frame_addr_pin_4_in};
      strap_sync_reg <= strap_meta_reg;
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         strap_reg        <= SPC_STRAP_RST;
         latch_d_reg      <= 1'b0;
         capture_pend_reg <= 1'b1;
      end else begin
         strap_reg        <= strap_next;
         latch_d_reg      <= monitor_id_latch_bit_in;
         capture_pend_reg <= 1'b0;
      end
   end

   // ==========================================================
   // Writable registers
   logic [7:0] scratch_reg;
   logic [7:0] memw_reg;
   logic [7:0] misc_reg;
   logic       wr_scratch;
   logic       wr_memw;
   logic       wr_misc;
   logic [3:0] reg_sel;

   // One decode serves the write strobes and the read mux, so the two cannot disagree.
   function automatic logic [3:0] spc_reg_sel(input logic [7:0] index);
      return {index == SPC_IDX_MISC, index == SPC_IDX_MEMW,
              index == SPC_IDX_STRAP, index == SPC_IDX_SCRATCH};
   endfunction : spc_reg_sel

   // The strap index has no write strobe at all, so host writes there are lost.
   assign reg_sel    = spc_reg_sel(reg_index_in);
   assign wr_scratch = reg_wr_in & reg_sel[0];
   assign wr_memw    = reg_wr_in & reg_sel[2];
   assign wr_misc    = reg_wr_in & reg_sel[3];

   // Scratch has an undefined reset value; it is cleared only for clean simulation.
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         scratch_reg <= SPC_SCRATCH_RST;
      end else if (wr_scratch) begin
         scratch_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         memw_reg <= SPC_MEMW_RST;
      end else if (wr_memw) begin
         memw_reg <= reg_wdata_in;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         misc_reg <= SPC_MISC_RST;
      end else if (wr_misc) begin
         misc_reg <= reg_wdata_in & SPC_MISC_WMASK;
      end
   end

   // ==========================================================
   // Read path and decoded controls
   logic [7:0]  rdata_next;
   logic        hit_next;
   logic [1:0]  p1_sel;
   logic [1:0]  p2_sel;
   logic [15:0] sleep_next;

   assign hit_next = (reg_index_in >= SPC_IDX_SCRATCH) & (reg_index_in <= SPC_IDX_MISC);
   // Strap register bits 7:5 always read zero; writes to it have no path.
   assign rdata_next = reg_sel[0] ? scratch_reg :
                       reg_sel[1] ? {3'h0, strap_reg} :
                       reg_sel[2] ? memw_reg :
                       reg_sel[3] ? misc_reg : 8'h00;
   // Companion mode forces the panel pin to its default function.
   assign p1_sel = companion_color_mode_enable_in ? SPC_P1_LINE_CLK :
                   misc_reg[SPC_MISC_P1_LO +: 2];
   assign p2_sel = misc_reg[SPC_MISC_P2_LO +: 2];
   assign sleep_next = strap_reg[SPC_STRAP_SLEEP] ? SPC_SLEEP_PORT_A
                                                  : SPC_SLEEP_PORT_B;

   // Reserved encodings 10 and 11 leave both panel selects low rather than guess a function.
   logic        line_clk_next;
   logic        data_en_next;
   logic        modulate_next;
   logic        sense_en_next;
   logic        sq_inv_next;

   assign line_clk_next = (p1_sel == SPC_P1_LINE_CLK);
   assign data_en_next  = (p1_sel == SPC_P1_DATA_EN);
   assign modulate_next = (p2_sel == SPC_P2_MODULATE);
   assign sense_en_next = ~misc_reg[SPC_MISC_SENSE_DIS];
   assign sq_inv_next   = misc_reg[SPC_MISC_SQ_INV];

   // ==========================================================
   // Register port outputs
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         reg_rdata_out <= 8'h00;
         reg_hit_out   <= 1'b0;
      end else begin
         reg_rdata_out <= rdata_next;
         reg_hit_out   <= hit_next;
      end
   end

   // ==========================================================
   // Strap-driven hardware controls
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         rom_width_16_out    <= 1'b0;
         sleep_port_addr_out <= SPC_SLEEP_PORT_A;
         rom_decode_en_out   <= 1'b1;
         reduced_decode_out  <= 1'b0;
         isa_bus_sel_out     <= 1'b0;
      end else begin
         rom_width_16_out    <= strap_reg[SPC_STRAP_WIDTH];
         sleep_port_addr_out <= sleep_next;
         rom_decode_en_out   <= strap_reg[SPC_STRAP_ROM_EN];
         reduced_decode_out  <= strap_reg[SPC_STRAP_REDUCED];
         isa_bus_sel_out     <= strap_reg[SPC_STRAP_ISA];
      end
   end

   // ==========================================================
   // Register-driven pin and clock controls
   always_ff @(posedge clk_sys_in) begin
      if (!nrst_in) begin
         memory_width_sel_out           <= 8'h00;
         panel_line_clock_sel_out       <= 1'b1;
         panel_data_enable_sel_out      <= 1'b0;
         panel_modulation_sel_out       <= 1'b0;
         monitor_sense_en_out           <= 1'b1;
         memory_sequencer_clock_inv_out <= 1'b0;
      end else begin
         memory_width_sel_out           <= memw_reg;
         panel_line_clock_sel_out       <= line_clk_next;
         panel_data_enable_sel_out      <= data_en_next;
         panel_modulation_sel_out       <= modulate_next;
         monitor_sense_en_out           <= sense_en_next;
         memory_sequencer_clock_inv_out <= sq_inv_next;
      end
   end

endmodule : spc_strap_pin_cfg

/* File: spc_strap_pin_cfg_monitor.sv */
// Purpose: Port assertions for the strap and pin configuration registers.
// Assumes: One clock domain with a synchronous active-low reset.
// Notes:   Outputs are registered, so checks skip the first edge after reset.
`timescale 1ns/1ns
module spc_strap_pin_cfg_monitor (
   input wire logic        clk_sys_in,
   input wire logic        nrst_in,
   input wire logic [7:0]  reg_index_in,
   input wire logic        reg_wr_in,
   input wire logic [7:0]  reg_wdata_in,
   input wire logic [7:0]  reg_rdata_out,
   input wire logic        reg_hit_out,
   input wire logic        monitor_id_latch_bit_in,
   input wire logic        companion_color_mode_enable_in,
   input wire logic        rom_width_16_out,
   input wire logic [15:0] sleep_port_addr_out,
   input wire logic        rom_decode_en_out,
   input wire logic        panel_line_clock_sel_out,
   input wire logic        panel_data_enable_sel_out,
   input wire logic        panel_modulation_sel_out,
   input wire logic        monitor_sense_en_out,
   input wire logic        memory_sequencer_clock_inv_out
);
   // ==========================================================
   // Assertions
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   property p_hit; $past(nrst_in) |-> reg_hit_out == ($past(reg_index_in[7:2]) == 6'h26);
   endproperty
   a_hit: assert property (p_hit) else $error("hit flag wrong");
   property p_unmap; $past(nrst_in) && $past(reg_index_in[7:2]) != 6'h26 |-> reg_rdata_out == 8'h00;
   endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_strap; $past(nrst_in) && $past(reg_index_in) == 8'h99 |-> reg_rdata_out[7:5] == 3'h0
      && reg_rdata_out[0] == rom_decode_en_out && reg_rdata_out[4] == rom_width_16_out
      && reg_rdata_out[3] == (sleep_port_addr_out == 16'h03C3); endproperty
   a_strap: assert property (p_strap) else $error("strap readback differs");
   property p_rsvd; $past(nrst_in) && $past(reg_index_in) == 8'h9B |-> !reg_rdata_out[7] && !reg_rdata_out[2];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("misc reserved bit set");
   property p_ctrl; reg_wr_in && reg_index_in == 8'h9B |-> ##2 monitor_sense_en_out == !$past(reg_wdata_in[1], 2)
      && memory_sequencer_clock_inv_out == $past(reg_wdata_in[0], 2); endproperty
   a_ctrl: assert property (p_ctrl) else $error("sense or clock phase wrong");
   property p_mod; reg_wr_in && reg_index_in == 8'h9B |-> ##2
      panel_modulation_sel_out == ($past(reg_wdata_in[4:3], 2) == 2'h1); endproperty
   a_mod: assert property (p_mod) else $error("modulation select wrong");
   property p_panel; reg_wr_in && reg_index_in == 8'h9B ##1 !companion_color_mode_enable_in |=>
      panel_data_enable_sel_out == ($past(reg_wdata_in[6:5], 2) == 2'h1)
      && panel_line_clock_sel_out == ($past(reg_wdata_in[6:5], 2) == 2'h0); endproperty
   a_panel: assert property (p_panel) else $error("panel pin select wrong");
   property p_comp; $past(nrst_in) && $past(companion_color_mode_enable_in) |->
      panel_line_clock_sel_out && !panel_data_enable_sel_out; endproperty
   a_comp: assert property (p_comp) else $error("companion mode not forcing line clock");
   property p_hold; !monitor_id_latch_bit_in [*4] |=>
      $stable({rom_width_16_out, rom_decode_en_out, sleep_port_addr_out}); endproperty
   a_hold: assert property (p_hold) else $error("strap changed without latch toggle");
   property p_sleep; sleep_port_addr_out == 16'h03C3 || sleep_port_addr_out == 16'h46E8; endproperty
   a_sleep: assert property (p_sleep) else $error("sleep port illegal");
endmodule : spc_strap_pin_cfg_monitor

/* File: tb.sv */
// Purpose: Self-checking bench for the strap and pin configuration registers.
// Assumes: Inputs change by non-blocking assignment on the rising edge.
// Notes:   A behavioural model predicts each register and control output.
`timescale 1ns/1ns
module tb;
   logic        clk = 1'b0, nrst = 1'b0, wr = 1'b0, latch = 1'b0, comp = 1'b0;
   logic [7:0]  idx = 8'h00, wd = 8'h00, rdata, memw_o, i, d;
   logic [4:0]  pins = 5'h09;
   logic [15:0] slp;
   logic        hit, w16, ren, rdec, isa, lck, den, mod, sen, inv;
   int          scr, mw, msc, stp, failures = 0, num_checks = 0;
   always #4 clk = ~clk;
   spc_strap_pin_cfg spc_strap_pin_cfg_inst (.clk_sys_in(clk), .nrst_in(nrst), .reg_index_in(idx),
      .reg_wr_in(wr), .reg_wdata_in(wd), .reg_rdata_out(rdata), .reg_hit_out(hit),
      .monitor_id_latch_bit_in(latch), .companion_color_mode_enable_in(comp),
      .frame_addr_pin_8_in(pins[4]), .frame_addr_pin_7_in(pins[3]), .frame_addr_pin_6_in(pins[2]),
      .frame_addr_pin_5_in(pins[1]), .frame_addr_pin_4_in(pins[0]), .rom_width_16_out(w16),
      .sleep_port_addr_out(slp), .rom_decode_en_out(ren), .reduced_decode_out(rdec),
      .isa_bus_sel_out(isa), .memory_width_sel_out(memw_o), .panel_line_clock_sel_out(lck),
      .panel_data_enable_sel_out(den), .panel_modulation_sel_out(mod),
      .monitor_sense_en_out(sen), .memory_sequencer_clock_inv_out(inv));
   // ==========================================================
   // Tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         failures++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk);
      idx <= a;
      wd <= v;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
      case (a)
         8'h98: scr = v;
         8'h9A: mw = v;
         8'h9B: msc = v & 8'h7B;
         default: ;
      endcase
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a);
      @(posedge clk);
      idx <= a;
      @(posedge clk);
      @(negedge clk);
      chk(rdata, a == 8'h98 ? scr : a == 8'h99 ? stp : a == 8'h9A ? mw : a == 8'h9B ? msc : 0);
      chk(hit, a[7:2] == 6'h26);
   endtask : rd_reg
   task automatic chk_out();
      chk(slp, stp[3] ? 16'h03C3 : 16'h46E8);
      chk({w16, rdec, isa, ren}, {stp[4], stp[2], stp[1], stp[0]});
      chk({lck, den}, {comp | (msc[6:5] == 0), !comp & (msc[6:5] == 1)});
      chk({mod, sen, inv}, {msc[4:3] == 1, !msc[1], msc[0]});
      chk(memw_o, mw);
   endtask : chk_out
   task automatic give_verdict();
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict
   // ==========================================================
   // Tests
   initial begin
      void'($urandom(74));
      {scr, mw, msc, stp} = {32'd0, 32'd0, 32'd0, 32'd9};
      repeat (6) @(posedge clk);
      nrst <= 1'b1;
      rd_reg(8'h99);
      chk_out();
      for (int n = 0; n < 64; n++) begin
         d = 8'($urandom);
         i = 8'h98 + 8'(n[1:0]);
         if (n[1:0] == 2'h2) d = 8'h00;
         if (n[1:0] == 2'h3) d = {1'b0, 4'(n[5:2]), 1'b0, d[1:0]};
         @(posedge clk);
         comp <= 1'($urandom);
         wr_reg(i, d);
         wr_reg(8'h97, ~d);
         rd_reg(i);
         rd_reg(8'h40 + 8'(d[5:0]));
         chk_out();
      end
      // Pins settle through the two-stage synchroniser before the latch bit falls.
      for (int n = 0; n < 6; n++) begin
         @(posedge clk);
         pins <= 5'($urandom);
         latch <= 1'b1;
         repeat (4) @(posedge clk);
         latch <= 1'b0;
         stp = pins;
         rd_reg(8'h99);
         chk_out();
      end
      @(posedge clk);
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      {scr, mw, msc} = {32'd0, 32'd0, 32'd0};
      rd_reg(8'h9B);
      chk_out();
      give_verdict();
   end
   initial begin
      repeat (20000) @(posedge clk);
      failures++;
      give_verdict();
   end
endmodule : tb
bind spc_strap_pin_cfg spc_strap_pin_cfg_monitor spc_strap_pin_cfg_monitor_inst (.clk_sys_in,
   .nrst_in, .reg_index_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out, .reg_hit_out,
   .monitor_id_latch_bit_in, .companion_color_mode_enable_in, .rom_width_16_out,
   .sleep_port_addr_out, .rom_decode_en_out, .panel_line_clock_sel_out,
   .panel_data_enable_sel_out, .panel_modulation_sel_out, .monitor_sense_en_out,
   .memory_sequencer_clock_inv_out);
